// [rtl/dpdt_pkg.sv]
// Holds register offsets, field positions, reset values and timing counts
// Assumes a 10 MHz clk_sys and an 8-bit register view on classic Wishbone
// Functional notes
// - Zero flag sets on decrement to zero
// - Interrupt request when enable and flag set
// - Timer 1 direction bit: 0 input, 1 output
// - Output latches data bit; input selects gate/event
// - Run bit low forces prescaler 7f, stopped
// - Run bit high lets prescaler count down
// - Divider select taps prescaler, 1 to 128
// - Prescaler read returns zero in bit 7
// - Prescaler fed by clock divided by twelve, or by pin rises in event mode
// - Gated counts while pin high; event on rise
// - Reset: count ff, prescaler 7f, control zero
// - Count write beats coincident decrement to zero
`default_nettype none
package dpdt_pkg;
  localparam logic [7:0] DPDT_T1_PSC_OFS = 8'hd2;
  localparam logic [7:0] DPDT_T1_CNT_OFS = 8'hd3;
  localparam logic [7:0] DPDT_T1_CTL_OFS = 8'hd4;
  localparam logic [7:0] DPDT_T2_PSC_OFS = 8'hd5;
  localparam logic [7:0] DPDT_T2_CNT_OFS = 8'hd6;
  localparam logic [7:0] DPDT_T2_CTL_OFS = 8'hd7;
  localparam logic [7:0] DPDT_IRQ_STAT_OFS = 8'hd8;
  localparam logic [7:0] DPDT_IRQ_CLR_OFS = 8'hd9;
  localparam logic [7:0] DPDT_IRQ_EN_OFS = 8'hda;
  localparam int DPDT_ZERO_BIT = 7;
  localparam int DPDT_IEN_BIT = 6;
  localparam int DPDT_DIR_BIT = 5;
  localparam int DPDT_DOUT_BIT = 4;
  localparam int DPDT_RUN_BIT = 3;
  localparam logic [7:0] DPDT_CNT_RST = 8'hff;
  localparam logic [6:0] DPDT_PSC_RST = 7'h7f;
  localparam logic [7:0] DPDT_CTL_RST = 8'h00;
  localparam int DPDT_CLK_HZ = 10000000;
  localparam int DPDT_FINT_DIV = 12;
  localparam logic [3:0] DPDT_FINT_LAST = 4'(DPDT_FINT_DIV - 1);
  localparam logic [7:0] DPDT_UNMAPPED_RD = 8'h00;
endpackage
`default_nettype wire

// [rtl/dpdt_tmr_if.sv]
// Interface carrying one timer's register access and events
// Assumes the top drives access strobes for one cycle
`default_nettype none
interface dpdt_tmr_if;
  logic wr_psc;
  logic wr_cnt;
  logic wr_ctl;
  logic [7:0] wdata;
  logic tick;
  logic pin_in;
  logic [7:0] ctl;
  logic [7:0] cnt;
  logic [6:0] timer1_prescaler_value;
  logic zero_evt;
  logic pin_out;
  logic pin_oe;
  logic irq;
  modport top (output wr_psc, wr_cnt, wr_ctl, wdata, tick, pin_in,
               input ctl, cnt, timer1_prescaler_value, zero_evt, pin_out, pin_oe, irq);
  modport tmr (input wr_psc, wr_cnt, wr_ctl, wdata, tick, pin_in,
               output ctl, cnt, timer1_prescaler_value, zero_evt, pin_out, pin_oe, irq);
endinterface
`default_nettype wire

// [rtl/dpdt_timer.sv]
// One prescaled 8-bit down timer with optional pin
// Assumes tick is a one-cycle enable at the divided-by-twelve rate
`default_nettype none
module dpdt_timer
  import dpdt_pkg::*;
#(
  parameter bit HAS_PIN = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  dpdt_tmr_if.tmr bus
);
  logic [7:0] ctl_ff;
  logic [7:0] cnt_ff;
  logic [6:0] psc_ff;
  logic pin_out_ff;
  logic pin_d_ff;
  logic [7:0] nxt_psc_full;
  logic [6:0] nxt_psc;
  logic psc_step;
  logic tap_rise;
  logic cnt_step;
  logic run;
  logic pin_mode_out;

  // ----------------------------------------------------------------
  // Prescaler input selection
  // ----------------------------------------------------------------
  assign run = ctl_ff[DPDT_RUN_BIT];
  assign pin_mode_out = HAS_PIN ? ctl_ff[DPDT_DIR_BIT] : 1'b1;
  always_comb begin
    if (pin_mode_out) begin
      psc_step = bus.tick;
    end else if (ctl_ff[DPDT_DOUT_BIT]) begin
      psc_step = bus.tick & bus.pin_in;
    end else begin
      psc_step = bus.pin_in & ~pin_d_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_d_ff <= 1'b1;
    end else begin
      pin_d_ff <= bus.pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Tap: the counter steps on the rising edge of the selected output
  // ----------------------------------------------------------------
  assign nxt_psc_full = {1'b0, psc_ff} - 8'h01;
  assign nxt_psc = nxt_psc_full[6:0];
  always_comb begin
    logic [7:0] cur_ext;
    logic [7:0] nxt_ext;
    cur_ext = {psc_ff, 1'b0};
    nxt_ext = {nxt_psc, 1'b1};
    // Code 0 steps with the prescaler input itself
    tap_rise = ~cur_ext[ctl_ff[2:0]] & nxt_ext[ctl_ff[2:0]];
    if (ctl_ff[2:0] == 3'h0) begin
      tap_rise = 1'b1;
    end
  end
  assign cnt_step = run & psc_step & tap_rise;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      psc_ff <= DPDT_PSC_RST;
    end else if (!run) begin
      psc_ff <= DPDT_PSC_RST;
    end else if (bus.wr_psc) begin
      psc_ff <= bus.wdata[6:0];
    end else if (psc_step) begin
      psc_ff <= nxt_psc;
    end
  end

  // ----------------------------------------------------------------
  // Counter, flag and control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_ff <= DPDT_CNT_RST;
    end else if (bus.wr_cnt) begin
      cnt_ff <= bus.wdata;
    end else if (cnt_step) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  assign bus.zero_evt = cnt_step & (cnt_ff == 8'h01) & ~bus.wr_cnt;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_ff <= DPDT_CTL_RST;
    end else begin
      if (bus.wr_ctl) begin
        ctl_ff <= bus.wdata;
      end
      if (bus.zero_evt) begin
        ctl_ff[DPDT_ZERO_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out_ff <= 1'b0;
    end else if (bus.zero_evt) begin
      pin_out_ff <= ctl_ff[DPDT_DOUT_BIT];
    end
  end

  assign bus.ctl = ctl_ff;
  assign bus.cnt = cnt_ff;
  assign bus.timer1_prescaler_value = psc_ff;
  assign bus.pin_out = pin_out_ff;
  assign bus.pin_oe = HAS_PIN & ctl_ff[DPDT_DIR_BIT];
  assign bus.irq = ctl_ff[DPDT_ZERO_BIT] & ctl_ff[DPDT_IEN_BIT];
endmodule
`default_nettype wire

// [rtl/dpdt_top.sv]
// Top of the dual prescaled down timer with Wishbone slave
// Assumes classic Wishbone, 8-bit data, clk_sys at 10 MHz, sync reset
`default_nettype none
module dpdt_top
  import dpdt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tmr_pin_i,
  output logic tmr_pin_o,
  output logic tmr_pin_oe,
  output logic t1_irq_o,
  output logic t2_irq_o,
  output logic irq_o
);
  dpdt_tmr_if t1();
  dpdt_tmr_if t2();
  logic [3:0] div_ff;
  logic tick_ff;
  logic ack_ff;
  logic [7:0] dat_ff;
  logic [1:0] stat_ff;
  logic [1:0] ien_ff;
  logic pin_o_ff;
  logic pin_oe_ff;
  logic t1_irq_ff;
  logic t2_irq_ff;
  logic irq_ff;
  logic req;
  logic wr;

  // ----------------------------------------------------------------
  // Divide-by-twelve enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == DPDT_FINT_LAST);
      div_ff <= (div_ff == DPDT_FINT_LAST) ? 4'h0 : div_ff + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i & wb_sel_i;
  assign t1.wdata = wb_dat_i;
  assign t2.wdata = wb_dat_i;
  assign t1.wr_psc = wr & (wb_adr_i == DPDT_T1_PSC_OFS);
  assign t1.wr_cnt = wr & (wb_adr_i == DPDT_T1_CNT_OFS);
  assign t1.wr_ctl = wr & (wb_adr_i == DPDT_T1_CTL_OFS);
  assign t2.wr_psc = wr & (wb_adr_i == DPDT_T2_PSC_OFS);
  assign t2.wr_cnt = wr & (wb_adr_i == DPDT_T2_CNT_OFS);
  assign t2.wr_ctl = wr & (wb_adr_i == DPDT_T2_CTL_OFS);
  assign t1.tick = tick_ff;
  assign t2.tick = tick_ff;
  assign t1.pin_in = tmr_pin_i;
  assign t2.pin_in = 1'b0;

  dpdt_timer #(.HAS_PIN(1'b1)) u_t1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(t1.tmr)
  );
  dpdt_timer #(.HAS_PIN(1'b0)) u_t2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(t2.tmr)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 8'h00;
    end else begin
      ack_ff <= req;
      if (req) begin
        case (wb_adr_i)
          DPDT_T1_PSC_OFS: dat_ff <= {1'b0, t1.timer1_prescaler_value};
          DPDT_T1_CNT_OFS: dat_ff <= t1.cnt;
          DPDT_T1_CTL_OFS: dat_ff <= t1.ctl;
          DPDT_T2_PSC_OFS: dat_ff <= {1'b0, t2.timer1_prescaler_value};
          DPDT_T2_CNT_OFS: dat_ff <= t2.cnt;
          DPDT_T2_CTL_OFS: dat_ff <= t2.ctl;
          DPDT_IRQ_STAT_OFS: dat_ff <= {6'h00, stat_ff};
          DPDT_IRQ_EN_OFS: dat_ff <= {6'h00, ien_ff};
          default: dat_ff <= DPDT_UNMAPPED_RD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky status, clear and enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_ff <= 2'h0;
      ien_ff <= 2'h0;
    end else begin
      if (wr && wb_adr_i == DPDT_IRQ_EN_OFS) begin
        ien_ff <= wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == DPDT_IRQ_CLR_OFS) begin
        stat_ff <= (stat_ff & ~wb_dat_i[1:0]) | {t2.zero_evt, t1.zero_evt};
      end else begin
        stat_ff <= stat_ff | {t2.zero_evt, t1.zero_evt};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_o_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      t1_irq_ff <= 1'b0;
      t2_irq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pin_o_ff <= t1.pin_out;
      pin_oe_ff <= t1.pin_oe;
      t1_irq_ff <= t1.irq;
      t2_irq_ff <= t2.irq;
      irq_ff <= |(stat_ff & ien_ff);
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign tmr_pin_o = pin_o_ff;
  assign tmr_pin_oe = pin_oe_ff;
  assign t1_irq_o = t1_irq_ff;
  assign t2_irq_o = t2_irq_ff;
  assign irq_o = irq_ff;
endmodule
`default_nettype wire

// [verification/dpdt_props.sv]
// Port checker for the dual timer block
// Assumes bind to dpdt_top, one clock, sync reset
`default_nettype none
module dpdt_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tmr_pin_oe,
  input wire logic t1_irq_o,
  input wire logic t2_irq_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk, wr, rd;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = tk & wb_we_i & wb_sel_i;
  assign rd = tk & ~wb_we_i;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ack_next: assert property (tk |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(tk)) else $error("ack unasked");
  a_psc_msb: assert property (rd && (wb_adr_i == 8'hd2 || wb_adr_i == 8'hd5)
    |=> !wb_dat_o[7]) else $error("psc bit7 set");
  a_unmapped_zero: assert property (rd && (wb_adr_i < 8'hd2 || wb_adr_i > 8'hda)
    |=> wb_dat_o == 8'h00) else $error("unmapped data");
  a_t1_masked: assert property (wr && wb_adr_i == 8'hd4 && !wb_dat_i[6]
    |=> ##1 !t1_irq_o) else $error("t1 irq masked");
  a_t2_masked: assert property (wr && wb_adr_i == 8'hd7 && !wb_dat_i[6]
    |=> ##1 !t2_irq_o) else $error("t2 irq masked");
  a_dir_oe: assert property (wr && wb_adr_i == 8'hd4
    |=> ##1 tmr_pin_oe == $past(wb_dat_i[5], 2)) else $error("oe wrong");
  a_irq_off: assert property (wr && wb_adr_i == 8'hda && wb_dat_i[1:0] == 2'b00
    |=> ##1 !irq_o) else $error("irq masked");
  a_rst_quiet: assert property ($fell(rst) |-> !wb_ack_o && !irq_o && !t1_irq_o
    && !t2_irq_o && !tmr_pin_oe) else $error("reset outputs");
endmodule
bind dpdt_top dpdt_props dpdt_props_i (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .tmr_pin_oe, .t1_irq_o,
  .t2_irq_o, .irq_o);
`default_nettype wire

// [verification/dpdt_pin_src.sv]
// Source and load on the timer-1 pin
// Assumes the bench steers the source at clock edges
`default_nettype none
module dpdt_pin_src (
  input wire logic src_en,
  input wire logic src_val,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device drive wins; an idle pin rises through its pull-up
  assign pin_lvl = pin_oe ? pin_o : (src_en ? src_val : 1'b1);
endmodule
`default_nettype wire

// [verification/dpdt_top_test.sv]
// Self-checking bench for the dual timer block
// Assumes dpdt_top, the pin source model and the bound checker
`default_nettype none
module dpdt_top_test import dpdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0, src_en = 1'b0, src_val = 1'b0;
  logic [7:0] adr = 8'h00, wdat = 8'h00, rdat;
  logic ack, pin_o, pin_oe, irq1, irq2, irq, pin_lvl;
  int fail_count = 0, n_checks = 0, cyc_n = 0;
  always #50 clk_sys = ~clk_sys;
  dpdt_top dpdt_top_i (.clk_sys, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tmr_pin_i(pin_lvl), .tmr_pin_o(pin_o), .tmr_pin_oe(pin_oe), .t1_irq_o(irq1),
    .t2_irq_o(irq2), .irq_o(irq));
  dpdt_pin_src dpdt_pin_src_i (.src_en, .src_val, .pin_o, .pin_oe, .pin_lvl);
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, s, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, 1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    logic [7:0] q;
    bus(1'b0, 1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? irq1 : k == 1 ? irq2 : k == 2 ? irq : pin_o;
  endfunction
  task automatic wait_hi(input int k, lim, output int n);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk({7'h00, sig(k)}, 8'h01);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    logic [7:0] exp[6] = '{8'h7f, 8'hff, 8'h00, 8'h7f, 8'hff, 8'h00};
    for (int i = 0; i < 6; i++) rd_chk(8'hd2 + 8'(i), exp[i]);
    rd_chk(8'hc0, 8'h00);
  endtask
  task automatic t_stop;
    logic [7:0] q;
    wr(8'hd2, 8'h10);
    wr(8'hd3, 8'h05);
    bus(1'b1, 1'b0, 8'hd3, 8'h09, q);
    wr(8'hd8, 8'hff);
    repeat (100) @(posedge clk_sys);
    rd_chk(8'hd2, 8'h7f);
    rd_chk(8'hd3, 8'h05);
    rd_chk(8'hd8, 8'h00);
  endtask
  task automatic t_zero;
    int n;
    wr(8'hda, 8'h01);
    wr(8'hd3, 8'h02);
    wr(8'hd4, 8'h68);
    wait_hi(0, 60, n);
    chk({7'h00, irq2}, 8'h00);
    rd_chk(8'hd4, 8'he8);
    rd_chk(8'hd8, 8'h01);
    wait_hi(2, 4, n);
    wr(8'hda, 8'h00);
    @(posedge clk_sys);
    chk({7'h00, irq}, 8'h00);
    rd_chk(8'hd8, 8'h01);
    wr(8'hda, 8'h01);
    wait_hi(2, 4, n);
    wr(8'hd9, 8'h01);
    rd_chk(8'hd8, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(8'hd4, 8'h40);
    @(posedge clk_sys);
    chk({7'h00, irq1}, 8'h00);
  endtask
  task automatic t_div;
    int n, lo, hi;
    for (int k = 0; k < 8; k++) begin
      lo = 12 * ((1 << k) - 1);
      hi = 12 * (1 << k) + 6;
      wr(8'hd6, 8'h01);
      wr(8'hd7, 8'h68 | 8'(k));
      wait_hi(1, hi, n);
      chk({7'h00, n >= lo}, 8'h01);
      wr(8'hd7, 8'h20);
    end
    chk({7'h00, irq1}, 8'h00);
  endtask
  task automatic t_out;
    int n;
    wr(8'hd3, 8'h01);
    wr(8'hd4, 8'h38);
    @(posedge clk_sys);
    chk({6'h00, pin_oe, pin_lvl}, 8'h02);
    wait_hi(3, 40, n);
    rd_chk(8'hd4, 8'hb8);
    wr(8'hd4, 8'h00);
    @(posedge clk_sys);
    chk({7'h00, pin_oe}, 8'h00);
  endtask
  task automatic t_pin(input logic gated);
    int n;
    @(posedge clk_sys);
    src_en <= 1'b1;
    src_val <= 1'b0;
    wr(8'hd3, 8'h01);
    wr(8'hd4, gated ? 8'h58 : 8'h48);
    repeat (60) @(posedge clk_sys);
    chk({7'h00, irq1}, 8'h00);
    src_val <= 1'b1;
    wait_hi(0, gated ? 40 : 8, n);
    wr(8'hd4, 8'h00);
    src_en <= 1'b0;
  endtask
  task automatic t_race;
    @(posedge clk_sys);
    src_en <= 1'b1;
    src_val <= 1'b0;
    wr(8'hd3, 8'h01);
    wr(8'hd4, 8'h08);
    fork
      wr(8'hd3, 8'h05);
      begin
        @(posedge clk_sys);
        src_val <= 1'b1;
      end
    join
    rd_chk(8'hd3, 8'h05);
    rd_chk(8'hd4, 8'h08);
    wr(8'hd4, 8'h00);
    src_en <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_stop;
    t_zero;
    t_div;
    t_out;
    t_pin(1'b1);
    t_pin(1'b0);
    t_race;
    finish_test;
  end
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      finish_test;
    end
  end
endmodule
`default_nettype wire
